// *** rtl/dwr_pkg.sv ***
package dwr_pkg;
    // Clock and packet time; one packet slot is PKT_CYC clock cycles.
    localparam int CLK_NS = 5;
    localparam int PACKET_NS = 10;
    localparam int PKT_CYC = (PACKET_NS + CLK_NS - 1) / CLK_NS;

    localparam int DEV_W = 1;
    localparam int BANK_W = 2;
    localparam int ROW_W = 2;
    localparam int COL_W = 2;
    localparam int LANE_W = 64;
    localparam int MASK_W = 16;
    localparam int NDEV = 1 << DEV_W;
    localparam int NBANK = 1 << (DEV_W + BANK_W);

    // Write-path delays in packet slots.
    localparam int RTR_SLOTS = 2;
    localparam int CWD_SLOTS = 1;

    // Slot counters saturate; intervals are compared at their width.
    localparam int TMR_W = 8;
    localparam logic [7:0] TMR_SAT = 8'hFF;
    localparam logic [7:0] RCD_SLOTS = 8'h03;
    localparam logic [7:0] RTR_T = 8'h02;
    localparam logic [7:0] CC_SLOTS = 8'h01;
    localparam logic [7:0] RAS_SLOTS = 8'h08;
    localparam logic [7:0] RTP_SLOTS = 8'h01;
    localparam logic [7:0] RC_SLOTS = 8'h0B;
    localparam logic [7:0] RP_SLOTS = 8'h03;

    typedef enum logic [1:0] {
        COL_WRITE, COL_WRITE_AP, COL_READ, COL_NOOP
    } dwr_col_e;
    typedef enum logic {ROW_ACT, ROW_PRE} dwr_row_e;
    typedef enum logic [2:0] {
        REQ_ACT, REQ_PRE, REQ_WRITE, REQ_WRITE_AP, REQ_READ
    } dwr_req_e;

    typedef struct packed {
        logic v;
        logic ap;
        logic [BANK_W-1:0] bank;
        logic [COL_W-1:0] col;
        logic [2*LANE_W-1:0] data;
    } dwr_entry_s;
endpackage : dwr_pkg

// *** rtl/dwr_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface dwr_link_if;
    logic slot;
    logic row_valid;
    dwr_pkg::dwr_row_e row_cmd;
    logic [dwr_pkg::DEV_W-1:0] row_dev;
    logic [dwr_pkg::BANK_W-1:0] row_bank;
    logic [dwr_pkg::ROW_W-1:0] row_addr;
    logic col_valid;
    dwr_pkg::dwr_col_e col_cmd;
    logic [dwr_pkg::DEV_W-1:0] col_dev;
    logic [dwr_pkg::BANK_W-1:0] col_bank;
    logic [dwr_pkg::COL_W-1:0] col_addr;
    logic mask_valid;
    logic [dwr_pkg::MASK_W-1:0] byte_mask;
    logic data_valid;
    logic [dwr_pkg::LANE_W-1:0] data_lane_a;
    logic [dwr_pkg::LANE_W-1:0] data_lane_b;
    logic q_valid;
    logic [dwr_pkg::LANE_W-1:0] q_lane_a;
    logic [dwr_pkg::LANE_W-1:0] q_lane_b;

    modport host_end(output slot, row_valid, row_cmd, row_dev, row_bank,
        row_addr, col_valid, col_cmd, col_dev, col_bank, col_addr,
        mask_valid, byte_mask, data_valid, data_lane_a, data_lane_b,
        input q_valid, q_lane_a, q_lane_b);
    modport dev_end(input slot, row_valid, row_cmd, row_dev, row_bank,
        row_addr, col_valid, col_cmd, col_dev, col_bank, col_addr,
        mask_valid, byte_mask, data_valid, data_lane_a, data_lane_b,
        output q_valid, q_lane_a, q_lane_b);
endinterface : dwr_link_if
`default_nettype wire

// *** rtl/dwr_wbuf.sv ***
`timescale 1ns/100ps
`default_nettype none
module dwr_wbuf #(
    parameter int RTR = dwr_pkg::RTR_SLOTS,
    parameter int CWD = dwr_pkg::CWD_SLOTS
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slot,
    input wire logic load,
    input wire logic load_ap,
    input wire logic [dwr_pkg::BANK_W-1:0] load_bank,
    input wire logic [dwr_pkg::COL_W-1:0] load_col,
    input wire logic data_valid,
    input wire logic [2*dwr_pkg::LANE_W-1:0] data_in,
    input wire logic retire_ok,
    input wire logic mask_valid,
    input wire logic [dwr_pkg::MASK_W-1:0] mask_in,
    output logic ret_valid,
    output dwr_pkg::dwr_entry_s ret_entry,
    output logic [dwr_pkg::MASK_W-1:0] ret_mask,
    output logic pending
);
    // ------------------------------------------------------------
    // Writes in flight, one stage per slot, then the held entry.
    // ------------------------------------------------------------
    dwr_pkg::dwr_entry_s st [1:RTR];
    dwr_pkg::dwr_entry_s held;
    logic retire_held;
    logic retire_new;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int k = 1; k <= RTR; k++) begin
                st[k] <= '0;
            end
        end else if (slot) begin
            st[1] <= '{v: load, ap: load_ap, bank: load_bank,
                       col: load_col, data: '0};
            for (int k = 2; k <= RTR; k++) begin
                st[k] <= st[k-1];
                if (k - 1 == CWD && data_valid) begin
                    st[k].data <= data_in;
                end
            end
        end
    end

    assign retire_held = retire_ok && held.v;
    assign retire_new = retire_ok && !held.v && st[RTR].v;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held <= '0;
        end else if (slot) begin
            if (retire_held) begin
                held <= st[RTR];
            end else if (!retire_ok && st[RTR].v) begin
                held <= st[RTR];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ret_valid <= 1'b0;
            ret_entry <= '0;
            ret_mask <= '0;
        end else begin
            ret_valid <= slot && (retire_held || retire_new);
            if (slot) begin
                ret_entry <= held.v ? held : st[RTR];
                ret_mask <= mask_valid ? mask_in : '1;
            end
        end
    end

    always_comb begin
        pending = held.v;
        for (int k = 1; k <= RTR; k++) begin
            pending = pending | st[k].v;
        end
    end
endmodule : dwr_wbuf
`default_nettype wire

// *** rtl/dwr_dev_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module dwr_dev_end (
    input wire logic clk,
    input wire logic rstn,
    dwr_link_if.dev_end link,
    output logic [dwr_pkg::NDEV-1:0] wr_pending,
    output logic [dwr_pkg::NDEV-1:0] retire_done
);
    localparam int AW = dwr_pkg::DEV_W + dwr_pkg::BANK_W
        + dwr_pkg::ROW_W + dwr_pkg::COL_W;
    localparam int DW = 2 * dwr_pkg::LANE_W;

    function automatic logic [AW-1:0] mem_addr(
        input logic [dwr_pkg::DEV_W-1:0] dev,
        input logic [dwr_pkg::BANK_W-1:0] bank,
        input logic [dwr_pkg::ROW_W-1:0] row,
        input logic [dwr_pkg::COL_W-1:0] col);
        return {dev, bank, row, col};
    endfunction : mem_addr

    logic [DW-1:0] mem [0:(1<<AW)-1];
    logic [dwr_pkg::ROW_W-1:0] open_row [0:dwr_pkg::NBANK-1];
    logic [dwr_pkg::NBANK-1:0] bank_open;
    dwr_pkg::dwr_entry_s ret_entry [0:dwr_pkg::NDEV-1];
    logic [dwr_pkg::MASK_W-1:0] ret_mask [0:dwr_pkg::NDEV-1];
    logic col_wr;
    logic col_rd;

    assign col_wr = link.col_valid && (link.col_cmd == dwr_pkg::COL_WRITE
        || link.col_cmd == dwr_pkg::COL_WRITE_AP);
    assign col_rd = link.col_valid && link.col_cmd == dwr_pkg::COL_READ;

    // ------------------------------------------------------------
    // One write buffer per device on the channel.
    // ------------------------------------------------------------
    for (genvar d = 0; d < dwr_pkg::NDEV; d++) begin : g_dev
        dwr_wbuf u_wbuf (
            .clk(clk),
            .rstn(rstn),
            .slot(link.slot),
            .load(col_wr && link.col_dev == d),
            .load_ap(link.col_cmd == dwr_pkg::COL_WRITE_AP),
            .load_bank(link.col_bank),
            .load_col(link.col_addr),
            .data_valid(link.data_valid),
            .data_in({link.data_lane_a, link.data_lane_b}),
            .retire_ok(link.col_valid
                && !(col_rd && link.col_dev == d)),
            .mask_valid(link.mask_valid),
            .mask_in(link.byte_mask),
            .ret_valid(retire_done[d]),
            .ret_entry(ret_entry[d]),
            .ret_mask(ret_mask[d]),
            .pending(wr_pending[d])
        );
    end

    // ------------------------------------------------------------
    // Open rows, closed by precharge or by an auto-precharge retire.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bank_open <= '0;
            for (int i = 0; i < dwr_pkg::NBANK; i++) begin
                open_row[i] <= '0;
            end
        end else begin
            for (int d = 0; d < dwr_pkg::NDEV; d++) begin
                if (retire_done[d] && ret_entry[d].ap) begin
                    bank_open[{d[dwr_pkg::DEV_W-1:0],
                               ret_entry[d].bank}] <= 1'b0;
                end
            end
            if (link.slot && link.row_valid) begin
                if (link.row_cmd == dwr_pkg::ROW_ACT) begin
                    open_row[{link.row_dev, link.row_bank}]
                        <= link.row_addr;
                    bank_open[{link.row_dev, link.row_bank}] <= 1'b1;
                end else begin
                    bank_open[{link.row_dev, link.row_bank}] <= 1'b0;
                end
            end
        end
    end

    // Retired bytes land in whatever row is open in the bank now.
    always_ff @(posedge clk) begin
        for (int d = 0; d < dwr_pkg::NDEV; d++) begin
            for (int b = 0; b < dwr_pkg::MASK_W; b++) begin
                if (retire_done[d] && ret_mask[d][b]) begin
                    mem[mem_addr(d[dwr_pkg::DEV_W-1:0], ret_entry[d].bank,
                        open_row[{d[dwr_pkg::DEV_W-1:0],
                        ret_entry[d].bank}], ret_entry[d].col)][b*8 +: 8]
                        <= ret_entry[d].data[b*8 +: 8];
                end
            end
        end
    end

    // A read sees the array only, so it returns old data until retire.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.q_valid <= 1'b0;
            link.q_lane_a <= '0;
            link.q_lane_b <= '0;
        end else begin
            link.q_valid <= link.slot && col_rd;
            if (link.slot && col_rd) begin
                {link.q_lane_a, link.q_lane_b} <= mem[mem_addr(link.col_dev,
                    link.col_bank, open_row[{link.col_dev, link.col_bank}],
                    link.col_addr)];
            end
        end
    end
endmodule : dwr_dev_end
`default_nettype wire

// *** rtl/dwr_host_end.sv ***
// Summary of operation
// - Write column follows activate by delay difference.
// - Write data follows each write command.
// - Command packets end-timed, data packets start-timed.
// - Column packets spaced; same device and bank.
// - Optional mask sent retire delay after write.
// - Without mask, every byte is written.
// - Postponed retire postpones its mask too.
// - Precharge no sooner than activate-to-precharge minimum; a write with auto-precharge skips this check.
// - Precharge waits after last retiring column packet.
// - Reactivate waits activate cycle and precharge time.
// - One transaction per bank at a time.
// - Write loads command, address, data into buffer.
// - Retire at delayed slot unless unframed or self-read.
// - Skipped retire happens on first eligible packet.
// - Reads before retire see old data.
// - Self-read in retire slot delays retire.
// - Other traffic forces the pending retire.
// - Write, write, read needs a no-op gap.
// - Late retire writes the currently open row.
// - Avoid precharging a bank with unretired write; precharge only waits RTR_T + RTP_SLOTS slots after the last write.
// - A write retires other devices' older writes.
// - Interleaved banks may use auto-precharge writes.
`timescale 1ns/100ps
`default_nettype none
module dwr_host_end (
    input wire logic clk,
    input wire logic rstn,
    dwr_link_if.host_end link,
    input wire logic req_valid,
    output logic req_ready,
    input wire dwr_pkg::dwr_req_e req_kind,
    input wire logic [dwr_pkg::DEV_W-1:0] req_dev,
    input wire logic [dwr_pkg::BANK_W-1:0] req_bank,
    input wire logic [dwr_pkg::ROW_W-1:0] req_row,
    input wire logic [dwr_pkg::COL_W-1:0] req_col,
    input wire logic [2*dwr_pkg::LANE_W-1:0] req_data,
    input wire logic req_mask_en,
    input wire logic [dwr_pkg::MASK_W-1:0] req_mask,
    output logic rd_valid,
    output logic [2*dwr_pkg::LANE_W-1:0] rd_data
);
    localparam int RTR = dwr_pkg::RTR_SLOTS;
    localparam int CWD = dwr_pkg::CWD_SLOTS;
    localparam int BI = dwr_pkg::DEV_W + dwr_pkg::BANK_W;

    // ------------------------------------------------------------
    // Packet slot divider.
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic slot_en;

    assign slot_en = div_cnt == 8'(dwr_pkg::PKT_CYC - 1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= slot_en ? '0 : div_cnt + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Per-bank interval counters and a shared column gap counter, in slots, saturating.
    // ------------------------------------------------------------
    logic [7:0] t_act [0:dwr_pkg::NBANK-1];
    logic [7:0] t_pre [0:dwr_pkg::NBANK-1];
    logic [7:0] t_wr [0:dwr_pkg::NBANK-1];
    logic [dwr_pkg::NBANK-1:0] active;
    logic [7:0] col_gap;
    logic [BI-1:0] idx;
    logic legal;
    logic rd_bubble;
    logic take;
    logic col_go;
    logic send_noop;
    dwr_pkg::dwr_col_e next_col;
    logic h1_wr;
    logic h2_wr;
    logic [dwr_pkg::DEV_W-1:0] h1_dev;
    logic [dwr_pkg::DEV_W-1:0] h2_dev;

    assign idx = {req_dev, req_bank};
    assign rd_bubble = req_kind == dwr_pkg::REQ_READ && h1_wr && h2_wr
        && h1_dev == req_dev && h2_dev == req_dev;

    always_comb begin
        unique case (req_kind)
            dwr_pkg::REQ_ACT: begin
                legal = !active[idx]
                    && t_act[idx] >= dwr_pkg::RC_SLOTS
                    && t_pre[idx] >= dwr_pkg::RP_SLOTS;
            end
            dwr_pkg::REQ_PRE: begin
                legal = active[idx]
                    && t_act[idx] >= dwr_pkg::RAS_SLOTS
                    && t_wr[idx] >= dwr_pkg::RTR_T
                    + dwr_pkg::RTP_SLOTS;
            end
            dwr_pkg::REQ_WRITE, dwr_pkg::REQ_WRITE_AP,
            dwr_pkg::REQ_READ: begin
                legal = active[idx] && !rd_bubble
                    && col_gap >= dwr_pkg::CC_SLOTS
                    && t_act[idx] >= dwr_pkg::RCD_SLOTS
                    - dwr_pkg::RTR_T;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end

    assign req_ready = slot_en && legal;
    assign take = req_valid && req_ready;
    assign send_noop = slot_en && req_valid && rd_bubble;
    assign col_go = send_noop || (take && req_kind != dwr_pkg::REQ_ACT
        && req_kind != dwr_pkg::REQ_PRE);

    always_comb begin
        unique case (req_kind)
            dwr_pkg::REQ_WRITE: next_col = dwr_pkg::COL_WRITE;
            dwr_pkg::REQ_WRITE_AP: next_col = dwr_pkg::COL_WRITE_AP;
            default: next_col = dwr_pkg::COL_READ;
        endcase
        if (send_noop) begin
            next_col = dwr_pkg::COL_NOOP;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            active <= '0;
            col_gap <= dwr_pkg::TMR_SAT;
            for (int i = 0; i < dwr_pkg::NBANK; i++) begin
                t_act[i] <= dwr_pkg::TMR_SAT;
                t_pre[i] <= dwr_pkg::TMR_SAT;
                t_wr[i] <= dwr_pkg::TMR_SAT;
            end
        end else if (slot_en) begin
            for (int i = 0; i < dwr_pkg::NBANK; i++) begin
                if (t_act[i] != dwr_pkg::TMR_SAT) t_act[i] <= t_act[i] + 8'h01;
                if (t_pre[i] != dwr_pkg::TMR_SAT) t_pre[i] <= t_pre[i] + 8'h01;
                if (t_wr[i] != dwr_pkg::TMR_SAT) t_wr[i] <= t_wr[i] + 8'h01;
            end
            col_gap <= col_go ? 8'h01
                : (col_gap == dwr_pkg::TMR_SAT ? col_gap : col_gap + 8'h01);
            if (take) begin
                unique case (req_kind)
                    dwr_pkg::REQ_ACT: begin
                        t_act[idx] <= '0;
                        active[idx] <= 1'b1;
                    end
                    dwr_pkg::REQ_PRE: begin
                        t_pre[idx] <= '0;
                        active[idx] <= 1'b0;
                    end
                    dwr_pkg::REQ_WRITE: begin
                        t_wr[idx] <= '0;
                    end
                    dwr_pkg::REQ_WRITE_AP: begin
                        t_wr[idx] <= '0;
                        t_pre[idx] <= '0;
                        active[idx] <= 1'b0;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Column history for the write-write-read hazard.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            h1_wr <= 1'b0;
            h2_wr <= 1'b0;
            h1_dev <= '0;
            h2_dev <= '0;
        end else if (slot_en) begin
            h1_wr <= col_go && (next_col == dwr_pkg::COL_WRITE
                || next_col == dwr_pkg::COL_WRITE_AP);
            h1_dev <= req_dev;
            h2_wr <= h1_wr;
            h2_dev <= h1_dev;
        end
    end

    // ------------------------------------------------------------
    // Data and mask delay lines.
    // ------------------------------------------------------------
    logic [CWD:1] dp_v;
    logic [2*dwr_pkg::LANE_W-1:0] dp_d [1:CWD];
    logic [RTR:1] mp_v;
    logic [dwr_pkg::MASK_W-1:0] mp_m [1:RTR];
    logic [dwr_pkg::DEV_W-1:0] mp_dev [1:RTR];
    logic mh_v;
    logic [dwr_pkg::MASK_W-1:0] mh_m;
    logic [dwr_pkg::DEV_W-1:0] mh_dev;
    logic take_wr;
    logic due_v;
    logic [dwr_pkg::DEV_W-1:0] due_dev;
    logic mask_go;

    assign take_wr = take && (req_kind == dwr_pkg::REQ_WRITE
        || req_kind == dwr_pkg::REQ_WRITE_AP);
    assign due_v = mh_v || mp_v[RTR];
    assign due_dev = mh_v ? mh_dev : mp_dev[RTR];
    assign mask_go = due_v && col_go && !(next_col == dwr_pkg::COL_READ
        && req_dev == due_dev);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dp_v <= '0;
            mp_v <= '0;
            mh_v <= 1'b0;
            mh_m <= '0;
            mh_dev <= '0;
            for (int k = 1; k <= CWD; k++) dp_d[k] <= '0;
            for (int k = 1; k <= RTR; k++) begin
                mp_m[k] <= '0;
                mp_dev[k] <= '0;
            end
        end else if (slot_en) begin
            dp_v[1] <= take_wr;
            dp_d[1] <= req_data;
            for (int k = 2; k <= CWD; k++) begin
                dp_v[k] <= dp_v[k-1];
                dp_d[k] <= dp_d[k-1];
            end
            mp_v[1] <= take_wr && req_mask_en;
            mp_m[1] <= req_mask;
            mp_dev[1] <= req_dev;
            for (int k = 2; k <= RTR; k++) begin
                mp_v[k] <= mp_v[k-1];
                mp_m[k] <= mp_m[k-1];
                mp_dev[k] <= mp_dev[k-1];
            end
            if (mask_go) begin
                mh_v <= mh_v && mp_v[RTR];
                mh_m <= mp_m[RTR];
                mh_dev <= mp_dev[RTR];
            end else if (mp_v[RTR]) begin
                mh_v <= 1'b1;
                mh_m <= mp_m[RTR];
                mh_dev <= mp_dev[RTR];
            end
        end
    end

    // ------------------------------------------------------------
    // Link packets: one clock wide, in the cycle after the slot.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            link.slot <= 1'b0;
            link.row_valid <= 1'b0;
            link.row_cmd <= dwr_pkg::ROW_ACT;
            link.row_dev <= '0;
            link.row_bank <= '0;
            link.row_addr <= '0;
            link.col_valid <= 1'b0;
            link.col_cmd <= dwr_pkg::COL_NOOP;
            link.col_dev <= '0;
            link.col_bank <= '0;
            link.col_addr <= '0;
            link.mask_valid <= 1'b0;
            link.byte_mask <= '0;
            link.data_valid <= 1'b0;
            link.data_lane_a <= '0;
            link.data_lane_b <= '0;
        end else begin
            link.slot <= slot_en;
            link.row_valid <= take && (req_kind == dwr_pkg::REQ_ACT
                || req_kind == dwr_pkg::REQ_PRE);
            link.col_valid <= col_go;
            link.mask_valid <= slot_en && mask_go;
            link.data_valid <= slot_en && dp_v[CWD];
            if (slot_en) begin
                link.row_cmd <= req_kind == dwr_pkg::REQ_PRE
                    ? dwr_pkg::ROW_PRE : dwr_pkg::ROW_ACT;
                link.row_dev <= req_dev;
                link.row_bank <= req_bank;
                link.row_addr <= req_row;
                link.col_cmd <= next_col;
                link.col_dev <= req_dev;
                link.col_bank <= req_bank;
                link.col_addr <= req_col;
                link.byte_mask <= mh_v ? mh_m : mp_m[RTR];
                {link.data_lane_a, link.data_lane_b} <= dp_d[CWD];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end else begin
            rd_valid <= link.q_valid;
            if (link.q_valid) begin
                rd_data <= {link.q_lane_a, link.q_lane_b};
            end
        end
    end
endmodule : dwr_host_end
`default_nettype wire

// *** dv/dwr_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module dwr_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic slot,
    input wire logic row_valid,
    input wire logic col_valid,
    input wire dwr_pkg::dwr_col_e col_cmd,
    input wire logic [dwr_pkg::DEV_W-1:0] col_dev,
    input wire logic mask_valid,
    input wire logic data_valid,
    input wire logic q_valid
);
    logic wr, rd;
    assign wr = col_valid && col_cmd inside {dwr_pkg::COL_WRITE,
        dwr_pkg::COL_WRITE_AP};
    assign rd = col_valid && col_cmd == dwr_pkg::COL_READ;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_slot_period: assert property (slot |=> !slot ##1 slot)
        else $error("slot strobe period wrong");
    a_row_framed: assert property (row_valid |-> slot)
        else $error("row packet off slot");
    a_col_spacing: assert property (col_valid |-> slot ##1 !col_valid)
        else $error("column packets too close");
    a_data_follows: assert property (wr |-> ##2 data_valid)
        else $error("write data missing");
    a_data_only_wr: assert property (!wr |-> ##2 !data_valid)
        else $error("data without write");
    a_mask_aligned: assert property (mask_valid |-> slot && col_valid)
        else $error("mask without retiring packet");
    a_read_answer: assert property (rd |=> q_valid)
        else $error("read not answered");
    a_q_no_stray: assert property (!rd |=> !q_valid)
        else $error("stray read data");
    a_wwr_gap: assert property (
        wr ##2 (wr && col_dev == $past(col_dev, 2))
        |-> ##2 !(rd && col_dev == $past(col_dev, 2)))
        else $error("read follows two writes");
endmodule : dwr_checker
`default_nettype wire

// *** dv/dram_write_retire_buffer_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module dram_write_retire_buffer_test;
    logic clk = 0, rstn = 0, req_valid = 0, req_ready, rd_valid;
    logic req_mask_en = 0, req_dev = 0;
    dwr_pkg::dwr_req_e req_kind = dwr_pkg::REQ_ACT;
    logic [1:0] req_row = 0, req_col = 0, wp, rdn;
    logic [127:0] req_data = 0, rd_data, w, x[2][4];
    logic [15:0] req_mask = 0;
    int errors = 0, n_checks = 0, seed = 54344, n_ret = 0;
    dwr_link_if link_if();
    dwr_host_end dwr_host_end_inst(.clk, .rstn, .link(link_if), .req_valid,
        .req_ready, .req_kind, .req_dev, .req_bank(2'h0), .req_row, .req_col,
        .req_data, .req_mask_en, .req_mask, .rd_valid, .rd_data);
    dwr_dev_end dwr_dev_end_inst(.clk, .rstn, .link(link_if),
        .wr_pending(wp), .retire_done(rdn));
    dwr_checker dwr_checker_inst(.clk, .rstn, .slot(link_if.slot),
        .row_valid(link_if.row_valid), .col_valid(link_if.col_valid),
        .col_cmd(link_if.col_cmd), .col_dev(link_if.col_dev),
        .mask_valid(link_if.mask_valid), .data_valid(link_if.data_valid),
        .q_valid(link_if.q_valid));
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) n_ret <= n_ret + rdn[0] + rdn[1];
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic op(input dwr_pkg::dwr_req_e k, input logic d,
        input logic [1:0] c, input logic [127:0] v, input logic me);
        int n = 0;
        @(negedge clk);
        {req_valid, req_dev, req_col} = {1'b1, d, c};
        req_kind = k;
        {req_data, req_mask_en, req_mask} = {v, me, 16'($random(seed))};
        #1;
        while (req_ready !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            chk(1'b0, "request never taken");
            finish_test;
        end else begin
            @(negedge clk);
            req_valid = 0;
        end
    endtask : op
    task automatic rd(input logic d, input logic [1:0] c,
        input logic [127:0] e);
        op(dwr_pkg::REQ_READ, d, c, 0, 0);
        repeat (2) @(negedge clk);
        chk(rd_valid === 1'b1 && rd_data === e, "read data");
    endtask : rd
    // Reads to device 1, 0 and 1 again retire every pending buffer.
    task automatic flush;
        op(dwr_pkg::REQ_READ, 1, 0, 0, 0);
        op(dwr_pkg::REQ_READ, 0, 0, 0, 0);
        op(dwr_pkg::REQ_READ, 1, 0, 0, 0);
    endtask : flush
    function automatic logic [127:0] mrg(input logic [127:0] o, n,
        input logic [15:0] m);
        for (int b = 0; b < 16; b++) begin
            mrg[8*b+:8] = m[b] ? n[8*b+:8] : o[8*b+:8];
        end
    endfunction : mrg
    initial begin
        int d, c;
        logic me;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rstn = 1;
        req_row = 1;
        op(dwr_pkg::REQ_ACT, 0, 0, 0, 0);
        op(dwr_pkg::REQ_ACT, 1, 0, 0, 0);
        for (int i = 0; i < 24; i++) begin
            d = (i < 8) ? i % 2 : $random(seed) & 1;
            c = (i < 8) ? i / 2 : $random(seed) & 3;
            w = {$random(seed), $random(seed), $random(seed), $random(seed)};
            me = i >= 8 && $random(seed) % 2 != 0;
            op(dwr_pkg::REQ_WRITE, d[0], c[1:0], w, me);
            x[d][c] = me ? mrg(x[d][c], w, req_mask) : w;
        end
        flush;
        for (int i = 0; i < 8; i++) rd(i[0], i[2:1], x[i[0]][i[2:1]]);
        op(dwr_pkg::REQ_WRITE, 0, 1, w, 0);
        op(dwr_pkg::REQ_WRITE, 0, 2, ~w, 0);
        rd(0, 1, w);
        chk(wp === 2'b01, "retire not held off");
        flush;
        rd(0, 2, ~w);
        chk(wp === 2'b00, "write left pending");
        op(dwr_pkg::REQ_PRE, 0, 0, 0, 0);
        req_row = 2;
        op(dwr_pkg::REQ_ACT, 0, 0, 0, 0);
        op(dwr_pkg::REQ_WRITE, 0, 3, w, 0);
        op(dwr_pkg::REQ_WRITE_AP, 1, 1, ~w, 0);
        op(dwr_pkg::REQ_ACT, 1, 0, 0, 0);
        flush;
        rd(0, 3, w);
        rd(1, 1, ~w);
        chk(n_ret == 28, "retire count");
        finish_test;
    end
endmodule : dram_write_retire_buffer_test
`default_nettype wire
